// File: gput_timer.v
// general purpose 32-bit up/down timer with 16-bit register port
//
// Operation
// - count prescaled clock ticks: 4, 16, 256, 32768
// - timer clock is the peripheral clock only
// - free up count wraps full scale to zero
// - free down count reloads full scale at zero
// - periodic up count returns zero on match C
// - periodic down count reloads full on match C
// - terminal point raises interrupt and reloads counter
// - control bit 4 picks periodic or free running
// - control bit 2 picks up or down counting
// - writing enable bit 0 starts counting
// - clearing enable stops counter and loads its start value
// - writing one to clear register drops flag
// - count read as halves, low read latches high
// - freeze holds both halves until high read
// - event during enable clear is held, raised later
// - interrupt enable also gates its comparison
// - status bit 8 flags enable change until synced
// - compare flags clear on status read
`timescale 1ns/1ps
`include "gput_defs.vh"

// behaviour summary for whoever integrates this block:
// - one clock only; the prescaler, the counter and the register port
//   all run from the same peripheral clock, so no real crossing exists
// - the enable still passes two flops before the counter sees it, so
//   software timing matches a part whose timer sits in a slow domain
// - status bit 8 shows that the enable has not yet reached the counter;
//   software polls it before touching control after a disable
// - the count is read as two halves; the low read catches the high half
//   so a carry between the two reads cannot tear the value
// - with the freeze bit set the low half is held as well, and a second
//   low read inside the hold returns the same value without relatching
// - the compare flags for fields a, b and c drop on a status read; the
//   roll flag drops only through the clear register
// - an event and a clear in the same cycle leave the flag set, so a
//   handler can never lose an event that lands as it clears
// - ordering rules for software (control only while disabled, field
//   updates only with their enable off) are not policed in hardware;
//   a write that breaks them is still taken as given
// - reserved bits are dropped on write and read back as zero, except
//   control bit 6, which has no function and always reads one
// limitation: free running roll takes the full 32-bit range of ticks,
// which no short test can reach; compares a and b are the quick probe

module gput_timer #(
    parameter CNT_W = 32                            // counter width
) (
    input  wire              clock,
    input  wire              rst_b,
    input  wire [5:0]        addr,
    input  wire              wr_en,
    input  wire              rd_en,
    input  wire [15:0]       wdata,
    output reg  [15:0]       rdata,
    output reg               irq
);

    reg  [`GPUT_CTRL_W-1:0]  ctrl_q;                // prescale, direction, freeze, free-run
    reg                      en_q;                  // enable bit as software wrote it
    reg  [1:0]               en_sync_q;             // enable passing into counter side
    reg  [15:0]              ta_lo_q;
    reg  [15:0]              ta_hi_q;
    reg  [15:0]              tb_lo_q;
    reg  [15:0]              tb_hi_q;
    reg  [15:0]              tc_lo_q;
    reg  [15:0]              tc_hi_q;
    reg  [`GPUT_IEN_W-1:0]   ien_q;                 // per-source enables
    reg  [`GPUT_IEN_W-1:0]   flag_q;                // sticky event flags
    reg  [`GPUT_IEN_W-1:0]   flag_d;
    reg                      sync_busy_q;           // status bit 8
    reg  [CNT_W-1:0]         cnt_q;                 // running count
    reg  [CNT_W-1:0]         cnt_d;
    reg  [`GPUT_PRE_W-1:0]   pre_q;                 // prescale divider
    reg  [15:0]              hi_latch_q;            // upper half caught at low read
    reg  [15:0]              lo_frz_q;              // lower half held during freeze
    reg                      frozen_q;              // freeze window open
    reg  [`GPUT_PRE_W-1:0]   pre_lim;
    reg  [15:0]              rdata_d;
    reg  [`GPUT_IEN_W-1:0]   evt;

    wire                     run       = en_sync_q[1];
    wire                     free_run  = ctrl_q[`GPUT_CTRL_FREE];
    wire                     count_dn  = ctrl_q[`GPUT_CTRL_DIR];
    wire [CNT_W-1:0]         start_val = count_dn ? `GPUT_FULL : `GPUT_ZERO;
    wire [CNT_W-1:0]         end_free  = count_dn ? `GPUT_ZERO : `GPUT_FULL;
    wire [CNT_W-1:0]         tc_val    = {tc_hi_q, tc_lo_q};
    wire                     tick      = run && (pre_q == pre_lim);
    wire                     at_c      = (cnt_q == tc_val);
    wire                     at_end    = free_run ? (cnt_q == end_free) : at_c;
    wire                     wr_ctrl   = wr_en && (addr == `GPUT_OFS_CTRL);
    wire                     wr_en_reg = wr_en && (addr == `GPUT_OFS_EN);
    wire                     wr_clr    = wr_en && (addr == `GPUT_OFS_CLR);
    wire                     rd_lo     = rd_en && (addr == `GPUT_OFS_CNT_LO);
    wire                     rd_hi     = rd_en && (addr == `GPUT_OFS_CNT_HI);
    wire                     rd_stat   = rd_en && (addr == `GPUT_OFS_STAT);

    // prescale limit from the divider field
    // the limit is one less than the divide ratio because the divider
    // counts from zero and restarts on the tick itself; a plain compare
    // was chosen over a one-hot decade chain to keep the area small
    always @*
    begin
        case (ctrl_q[1:0])
            2'h0:    pre_lim = `GPUT_PRE_DIV4;
            2'h1:    pre_lim = `GPUT_PRE_DIV16;
            2'h2:    pre_lim = `GPUT_PRE_DIV256;
            default: pre_lim = `GPUT_PRE_DIV32K;
        endcase
    end

    // prescaler runs from the one peripheral clock; no other source exists
    // it is held at zero while the timer is stopped so the first tick
    // after an enable always lands one full prescale period later
    // a control change while running would distort one period, up to a full 15-bit wrap,
    // which is why software must disable before changing the divider
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            pre_q <= {`GPUT_PRE_W{1'b0}};
        else if (!run || tick)
            pre_q <= {`GPUT_PRE_W{1'b0}};
        else
            pre_q <= pre_q + 1'b1;
    end

    // next count: terminal point reloads start value, else step
    // the terminal test uses the current value, so the match value is
    // shown for one full prescale period before the reload happens
    // in periodic mode field c is the terminal; a field c that the count
    // never passes makes the timer run the full range without reload
    always @*
    begin
        if (!run)
            cnt_d = start_val;
        else if (!tick)
            cnt_d = cnt_q;
        else if (at_end)
            cnt_d = start_val;
        else if (count_dn)
            cnt_d = cnt_q - 1'b1;
        else
            cnt_d = cnt_q + 1'b1;
    end

    // the count itself; disabled timer sits at its start point
    // reset puts zero here; the first cycle out of reset then loads the
    // start value of the selected direction through the stopped branch
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            cnt_q <= `GPUT_ZERO;
        else
            cnt_q <= cnt_d;
    end

    // compare events, each gated by its own enable so a masked
    // compare never marks status; roll only in free running mode
    // events are taken only on a tick, so a match that stands for many
    // clocks between ticks raises its flag exactly once
    // software that changes a field must mask it first, else a half
    // written value could match for one tick and flag a false event
    always @*
    begin
        evt = {`GPUT_IEN_W{1'b0}};
        if (tick)
        begin
            evt[`GPUT_BIT_A] = ien_q[`GPUT_BIT_A] &&
                               (cnt_q == {ta_hi_q, ta_lo_q});
            evt[`GPUT_BIT_B] = ien_q[`GPUT_BIT_B] &&
                               (cnt_q == {tb_hi_q, tb_lo_q});
            evt[`GPUT_BIT_C] = ien_q[`GPUT_BIT_C] && at_c;
            evt[`GPUT_BIT_ROLL] = ien_q[`GPUT_BIT_ROLL] && free_run && at_end;
        end
    end

    // sticky flags: set wins over any clear in the same cycle
    // the clear register and the status read may both act at once;
    // they only ever remove bits, and new events are ored in last
    always @*
    begin
        flag_d = flag_q;
        if (wr_clr)
            flag_d = flag_d & ~wdata[`GPUT_IEN_W-1:0];
        if (rd_stat)
        begin
            flag_d[`GPUT_BIT_A] = 1'b0;
            flag_d[`GPUT_BIT_B] = 1'b0;
            flag_d[`GPUT_BIT_C] = 1'b0;
        end
        flag_d = flag_d | evt;
    end

    // flags persist; line follows any flag whose enable is now set,
    // so an event caught as its enable fell fires once re-enabled
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flag_q <= {`GPUT_IEN_W{1'b0}};
            irq    <= 1'b0;
        end
        else
        begin
            flag_q <= flag_d;
            irq    <= |(flag_d & ien_q);
        end
    end

    // enable bit, its two-stage crossing and the busy indicator
    // the counter sees a new enable two clocks after the write; busy
    // rises at the write edge and falls once the second stage agrees,
    // so a write of the same value still shows busy for a short while
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            en_q        <= 1'b0;
            en_sync_q   <= 2'h0;
            sync_busy_q <= 1'b0;
        end
        else
        begin
            if (wr_en_reg)
                en_q <= wdata[0];
            en_sync_q <= {en_sync_q[0], en_q};
            // busy from any enable write until the counter side agrees
            if (wr_en_reg)
                sync_busy_q <= 1'b1;
            else if (en_sync_q[1] == en_q)
                sync_busy_q <= 1'b0;
        end
    end

    // configuration registers; only live bits are kept
    // dropping the reserved bits here keeps the read mux simple and
    // guarantees that a stray write can never turn on unused logic
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_q  <= `GPUT_RST_CTRL;
            ta_lo_q <= `GPUT_RST_TA_LO;
            ta_hi_q <= 16'h0000;
            tb_lo_q <= `GPUT_RST_TB_LO;
            tb_hi_q <= 16'h0000;
            tc_lo_q <= `GPUT_RST_TC_LO;
            tc_hi_q <= 16'h0000;
            ien_q   <= {`GPUT_IEN_W{1'b0}};
        end
        else if (wr_en)
        begin
            // writes are taken as given; ordering is software's duty
            case (addr)
                `GPUT_OFS_CTRL:  ctrl_q  <= wdata[`GPUT_CTRL_W-1:0];
                `GPUT_OFS_TA_LO: ta_lo_q <= wdata;
                `GPUT_OFS_TA_HI: ta_hi_q <= wdata;
                `GPUT_OFS_TB_LO: tb_lo_q <= wdata;
                `GPUT_OFS_TB_HI: tb_hi_q <= wdata;
                `GPUT_OFS_TC_LO: tc_lo_q <= wdata;
                `GPUT_OFS_TC_HI: tc_hi_q <= wdata;
                `GPUT_OFS_IEN:   ien_q   <= wdata[`GPUT_IEN_W-1:0];
                default:         ;
            endcase
        end
    end

    // split count read; low read latches upper half, freeze holds both
    // without freeze the high half is still caught at each low read; the
    // hold window only matters when software is slow between the reads
    // a high read with no low read before it returns the last catch
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hi_latch_q <= 16'h0000;
            lo_frz_q   <= 16'h0000;
            frozen_q   <= 1'b0;
        end
        else if (rd_lo && !frozen_q)
        begin
            hi_latch_q <= cnt_q[31:16];
            lo_frz_q   <= cnt_q[15:0];
            frozen_q   <= ctrl_q[`GPUT_CTRL_FREEZE];
        end
        else if (rd_hi)
            frozen_q <= 1'b0;
    end

    // read mux; unmapped and write-only addresses read zero
    // the mux is decoded every cycle but only loaded on a read strobe,
    // so the side effects of a read happen once, at the strobe edge
    always @*
    begin
        rdata_d = 16'h0000;
        case (addr)
            `GPUT_OFS_CNT_LO: rdata_d = frozen_q ? lo_frz_q : cnt_q[15:0];
            `GPUT_OFS_CNT_HI: rdata_d = hi_latch_q;
            `GPUT_OFS_CTRL:   rdata_d = {11'h000, ctrl_q} | `GPUT_RST_CTRL_RD;
            `GPUT_OFS_EN:     rdata_d = {15'h0000, en_q};
            `GPUT_OFS_TA_LO:  rdata_d = ta_lo_q;
            `GPUT_OFS_TA_HI:  rdata_d = ta_hi_q;
            `GPUT_OFS_TB_LO:  rdata_d = tb_lo_q;
            `GPUT_OFS_TB_HI:  rdata_d = tb_hi_q;
            `GPUT_OFS_TC_LO:  rdata_d = tc_lo_q;
            `GPUT_OFS_TC_HI:  rdata_d = tc_hi_q;
            `GPUT_OFS_IEN:    rdata_d = {12'h000, ien_q};
            `GPUT_OFS_STAT:
            begin
                rdata_d[`GPUT_IEN_W-1:0]  = flag_q;
                rdata_d[`GPUT_STAT_FRZ]   = frozen_q;
                rdata_d[`GPUT_STAT_SYNC]  = sync_busy_q;
            end
            default:          rdata_d = 16'h0000;
        endcase
    end

    // registered read data: valid the cycle after rd_en
    // holding the value between reads lets a slow master take it late
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= 16'h0000;
        else if (rd_en)
            rdata <= rdata_d;
    end

endmodule // gput_timer

// File: gput_defs.vh
// register map, field positions, reset values and prescale figures of the general purpose timer
`ifndef GPUT_DEFS_VH
`define GPUT_DEFS_VH
`define GPUT_OFS_CNT_LO     6'h00
`define GPUT_OFS_CNT_HI     6'h04
`define GPUT_OFS_CTRL       6'h08
`define GPUT_OFS_EN         6'h0c
`define GPUT_OFS_TA_LO      6'h10
`define GPUT_OFS_TA_HI      6'h14
`define GPUT_OFS_TB_LO      6'h18
`define GPUT_OFS_TB_HI      6'h1c
`define GPUT_OFS_TC_LO      6'h20
`define GPUT_OFS_TC_HI      6'h24
`define GPUT_OFS_IEN        6'h28
`define GPUT_OFS_STAT       6'h2c
`define GPUT_OFS_CLR        6'h30
`define GPUT_RST_CTRL       5'h00
`define GPUT_RST_CTRL_RD    16'h0040
`define GPUT_RST_TA_LO      16'h1fff
`define GPUT_RST_TB_LO      16'h2fff
`define GPUT_RST_TC_LO      16'h3fff
`define GPUT_CTRL_W         5
`define GPUT_CTRL_FREE      4
`define GPUT_CTRL_FREEZE    3
`define GPUT_CTRL_DIR       2
`define GPUT_IEN_W          4
`define GPUT_BIT_A          0
`define GPUT_BIT_B          1
`define GPUT_BIT_C          2
`define GPUT_BIT_ROLL       3
`define GPUT_STAT_FRZ       7
`define GPUT_STAT_SYNC      8
`define GPUT_PRE_W          15
`define GPUT_PRE_DIV4       15'h0003
`define GPUT_PRE_DIV16      15'h000f
`define GPUT_PRE_DIV256     15'h00ff
`define GPUT_PRE_DIV32K     15'h7fff
`define GPUT_FULL           32'hffffffff
`define GPUT_ZERO           32'h00000000
`define GPUT_SYNC_STAGES    2'h2
`endif

// File: gput_monitor.sv
// checker on the timer's register port and interrupt line
`timescale 1ns/1ps
module gput_monitor (
    input wire        clock,
    input wire        rst_b,
    input wire [5:0]  addr,
    input wire        wr_en,
    input wire        rd_en,
    input wire [15:0] wdata,
    input wire [15:0] rdata,
    input wire        irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    // read data only moves when a read is taken
    property p_rd_hold; !rd_en |=> $stable(rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    // unmapped offsets above the clear register answer zero
    property p_unmap; rd_en && addr > 6'h30 |=> rdata == 16'h0000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    // clear register is write only
    property p_clr_rd; rd_en && addr == 6'h30 |=> rdata == 16'h0000; endproperty
    a_clr_rd: assert property (p_clr_rd) else $error("clear read");
    property p_en_rd; rd_en && addr == 6'h0c |=> rdata[15:1] == 15'h0000; endproperty
    a_en_rd: assert property (p_en_rd) else $error("enable spare bits");
    // bit 6 always reads one, the rest above bit 4 zero
    property p_ctrl_rd; rd_en && addr == 6'h08 |=> rdata[15:5] == 11'h002; endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control spare bits");
    property p_ien_rd; rd_en && addr == 6'h28 |=> rdata[15:4] == 12'h000; endproperty
    a_ien_rd: assert property (p_ien_rd) else $error("enable mask spare bits");
    property p_sta_rd;
        rd_en && addr == 6'h2c |=> rdata[15:9] == 7'h00 && rdata[6:4] == 3'h0;
    endproperty
    a_sta_rd: assert property (p_sta_rd) else $error("status spare bits");
    // masking every source silences the line two edges later
    property p_ien_off; wr_en && addr == 6'h28 && wdata[3:0] == 4'h0 |-> ##2 !irq; endproperty
    a_ien_off: assert property (p_ien_off) else $error("irq with all masked");
    c_irq: cover property ($rose(irq));
    c_sync: cover property (rd_en && addr == 6'h2c ##1 rdata[8]);
    c_frz: cover property (rd_en && addr == 6'h2c ##1 rdata[7]);
endmodule // gput_monitor

// File: gput_host.sv
// partner model: processor side of the timer register port
`timescale 1ns/1ps
module gput_host (
    input  wire        clock,
    input  wire [15:0] rdata,
    output reg  [5:0]  addr,
    output reg         wr_en,
    output reg         rd_en,
    output reg  [15:0] wdata
);
    // idle bus at time zero
    initial
    begin
        addr = 6'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        wdata = 16'h0000;
    end
    // one write, strobe seen at exactly one edge
    task wr(input [5:0] a, input [15:0] d);
        @(posedge clock) #1;
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(posedge clock) #1;
        wr_en = 1'b0;
        wdata = ~d; // released data never looks stale
    endtask
    // one read, answer taken one edge after the strobe
    task rd(input [5:0] a, output [15:0] d);
        @(posedge clock) #1;
        addr = a;
        rd_en = 1'b1;
        @(posedge clock) #1;
        rd_en = 1'b0;
        d = rdata;
    endtask
endmodule // gput_host

// File: tb.sv
// self-checking bench for the general purpose timer
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb;
    reg         clock = 1'b0;          // peripheral clock
    reg         rst_b = 1'b0;          // reset, active low
    wire [5:0]  addr;
    wire        wr_en;
    wire        rd_en;
    wire [15:0] wdata;
    wire [15:0] rdata;
    wire        irq;
    int         fail_count = 0;
    int         compares = 0;
    int         n, k, t;
    reg  [16:0] expq[$];               // bit 16 marks a checked read
    reg  [16:0] e;
    reg         rd_d = 1'b0;           // a read was taken last edge
    reg  [31:0] seed = 32'h58b70d92;
    reg  [15:0] v;
    localparam logic [21:0] RV [0:11] = '{{6'h08, 16'h0040}, {6'h0c, 16'h0}, {6'h10, 16'h1fff},
        {6'h14, 16'h0}, {6'h18, 16'h2fff}, {6'h1c, 16'h0}, {6'h20, 16'h3fff}, {6'h24, 16'h0},
        {6'h28, 16'h0}, {6'h2c, 16'h0}, {6'h30, 16'h0}, {6'h34, 16'h0}};
    int DV [0:4] = '{4, 16, 256, 32768, 4};   // divide per prescaler code
    int TK [0:4] = '{1, 1, 1, 1, 15};         // ticks to the field C match
    always #5 clock = ~clock;
    gput_host host_u (.clock(clock), .rdata(rdata), .addr(addr), .wr_en(wr_en),
        .rd_en(rd_en), .wdata(wdata));
    gput_timer #(.CNT_W(32)) dut_u (.clock(clock), .rst_b(rst_b), .addr(addr),
        .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .irq(irq));
    function [31:0] xs(input [31:0] s);
        reg [31:0] r;
        begin
            r = s ^ (s << 13);
            r = r ^ (r >> 17);
            xs = r ^ (r << 5);
        end
    endfunction
    // note the expectation, then read through the processor model
    task rd(input [5:0] a, input [15:0] x, input bit c);
        expq.push_back({c, x});
        host_u.rd(a, v);
    endtask
    // result watcher: each answered read takes the oldest note
    always @(posedge clock)
    begin
        if (rd_d && expq.size() > 0)
        begin
            e = expq.pop_front();
            if (e[16]) `CHK(rdata, e[15:0])
        end
        rd_d <= rd_en;
    end
    task complete_run;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog: the longest prescaler run needs about 65536 cycles
    initial
    begin
        #1000us;
        fail_count++;
        complete_run;
    end
    initial
    begin
        repeat (3) @(posedge clock);
        #1 rst_b = 1'b1;
        for (n = 0; n < 12; n++)
            rd(RV[n][21:16], RV[n][15:0], 1);
        $display("test reset values done");
        // random fields while disabled; a stopped count reads its start value
        for (n = 0; n < 3; n++)
        begin
            seed = xs(seed);
            host_u.wr(6'h14, seed[15:0]);
            rd(6'h14, seed[15:0], 1);
            host_u.wr(6'h08, seed[31:16]);
            rd(6'h08, (seed[31:16] & 16'h001f) | 16'h0040, 1);
            host_u.wr(6'h00, seed[15:0]);
            host_u.wr(6'h34, seed[15:0]);
            rd(6'h00, {16{seed[18]}}, 1);
            rd(6'h2c, {8'h00, seed[19], 7'h00}, 1);
            rd(6'h04, {16{seed[18]}}, 1);
            rd(6'h2c, 16'h0000, 1);
        end
        $display("test random fields done");
        // each prescaler code, then a periodic down count
        for (n = 0; n < 5; n++)
        begin
            host_u.wr(6'h08, (n == 4) ? 16'h0004 : n[15:0]);
            host_u.wr(6'h24, (n == 4) ? 16'hffff : 16'h0000);
            host_u.wr(6'h20, (n == 4) ? 16'hfff0 : 16'h0001);
            host_u.wr(6'h28, 16'h0004);
            host_u.wr(6'h0c, 16'h0001);
            rd(6'h2c, 16'h0100, 1);
            for (t = 0; !irq && t < 70000; t++)
                @(posedge clock);
            `CHK(t >= DV[n] * TK[n] - 4 && t <= DV[n] * (TK[n] + 1) + 8, 1'b1)
            host_u.wr(6'h0c, 16'h0000);
            rd(6'h2c, 16'h0104, 1);
            v = 16'h0100;
            for (k = 0; k < 8 && v[8]; k++)
                rd(6'h2c, 16'h0000, 0);
            `CHK(v[8], 1'b0)
            host_u.wr(6'h30, 16'h000f);
            repeat (2) @(posedge clock);
            `CHK(irq, 1'b0)
            rd(6'h2c, 16'h0000, 1);
            host_u.wr(6'h28, 16'h0000);
            $display("test period %0d done", n);
        end
        // free running up count, compare a alone drives the line
        host_u.wr(6'h08, 16'h0010);
        host_u.wr(6'h14, 16'h0000);
        host_u.wr(6'h10, 16'h0005);
        host_u.wr(6'h28, 16'h0001);
        host_u.wr(6'h0c, 16'h0001);
        for (t = 0; !irq && t < 200; t++)
            @(posedge clock);
        `CHK(t < 200, 1'b1)
        rd(6'h2c, 16'h0001, 1);
        rd(6'h2c, 16'h0000, 1);
        `CHK(irq, 1'b0)
        host_u.wr(6'h0c, 16'h0000);
        repeat (4) @(posedge clock);
        rd(6'h2c, 16'h0000, 1);
        rd(6'h00, 16'h0000, 1);
        rd(6'h04, 16'h0000, 1);
        host_u.wr(6'h28, 16'h0000);
        $display("test free run done");
        repeat (3) @(posedge clock);
        complete_run;
    end
endmodule // tb
bind gput_timer gput_monitor mon_u (.clock(clock), .rst_b(rst_b), .addr(addr),
    .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .irq(irq));
